/* hw/ebram_top.sv */
// Embedded block RAM with flash shadow load and write-back
//
// Overview of operation
// RULE_01 - 18 Kbit storage with registered inputs and registered outputs.
// RULE_02 - Single-port, true dual-port, or pseudo dual-port with one write, one read port.
// RULE_03 - Shapes 16384x1 down to 512x36; true dual-port excludes 512x36.
// RULE_04 - Optional parity bit stored beside every data byte.
// RULE_05 - Per-byte write enables on 18- and 36-bit wide ports.
// RULE_06 - Each port of a multi-port mode picks its own width.
// RULE_07 - Bits laid out word 0 LSB to MSB, then word 1, per port.
// RULE_08 - Shadow contents copied into the RAM at power-up and every reconfiguration.
// RULE_09 - RAM contents can be copied back into the flash shadow.
// RULE_10 - Write-back happens only when user logic explicitly requests it.
// RULE_11 - User logic avoids both ports writing one address in one cycle.
// RULE_12 - All accesses synchronous; output register adds one cycle of read latency.
`timescale 1ns/1ps
`default_nettype none
module ebram_top (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  mode,
  input  wire logic        parity_en,
  input  wire logic        reconfig_req,
  input  wire logic        writeback_req,
  input  wire logic [2:0]  a_width,
  input  wire logic        a_oreg_en,
  input  wire logic        a_en,
  input  wire logic        a_we,
  input  wire logic [13:0] a_addr,
  input  wire logic [35:0] a_wdata,
  input  wire logic [3:0]  a_be,
  output logic      [35:0] a_rdata,
  output logic             a_rvalid,
  input  wire logic [2:0]  b_width,
  input  wire logic        b_oreg_en,
  input  wire logic        b_en,
  input  wire logic        b_we,
  input  wire logic [13:0] b_addr,
  input  wire logic [35:0] b_wdata,
  input  wire logic [3:0]  b_be,
  output logic      [35:0] b_rdata,
  output logic             b_rvalid,
  output logic             busy,
  output logic             cfg_error
);
  import ebram_pkg::*;
  // ****************************************
  // Storage and shadow
  // ****************************************
  logic [8:0]   ram    [ENTRIES];
  logic [8:0]   shadow [ENTRIES];
  ebram_state_t state;
  ebram_state_t next_state;
  logic [10:0]  idx;
  logic [10:0]  next_idx;
  logic         next_cfg_error;
  logic         a_bad;
  logic         b_bad;
  logic         tdp;
  logic         sp;
  logic         pdp;
  logic         a_rd_ok;
  logic         b_rd_ok;
  logic         b_wr_ok;
  ebram_port_if pa ();
  ebram_port_if pb ();
  // ****************************************
  // Mode decode
  // ****************************************
  assign tdp     = (mode == MODE_TDP);
  assign pdp     = (mode == MODE_PDP);
  assign sp      = !tdp && !pdp;
  assign a_rd_ok = !pdp; // [RULE_02]
  assign b_wr_ok = tdp; // [RULE_02]
  assign b_rd_ok = tdp || pdp; // [RULE_02]
  assign busy    = (state != ST_IDLE);
  assign next_cfg_error = (mode > MODE_PDP) || a_bad || (!sp && b_bad); // [RULE_03]
  // ****************************************
  // Ports, each with its own width
  // ****************************************
  ebram_port u_port_a ( // [RULE_06]
    .clk       (clk),
    .rst_b     (rst_b),
    .width     (a_width),
    .oreg_en   (a_oreg_en),
    .parity_en (parity_en),
    .tdp       (tdp),
    .wr_allow  (1'b1),
    .rd_allow  (a_rd_ok),
    .busy      (busy),
    .en        (a_en),
    .we        (a_we),
    .addr      (a_addr),
    .wdata     (a_wdata),
    .be        (a_be),
    .rdata     (a_rdata),
    .rvalid    (a_rvalid),
    .bad       (a_bad),
    .pif       (pa.port)
  );
  ebram_port u_port_b ( // [RULE_06]
    .clk       (clk),
    .rst_b     (rst_b),
    .width     (b_width),
    .oreg_en   (b_oreg_en),
    .parity_en (parity_en),
    .tdp       (tdp),
    .wr_allow  (b_wr_ok),
    .rd_allow  (b_rd_ok),
    .busy      (busy),
    .en        (b_en),
    .we        (b_we),
    .addr      (b_addr),
    .wdata     (b_wdata),
    .be        (b_be),
    .rdata     (b_rdata),
    .rvalid    (b_rvalid),
    .bad       (b_bad),
    .pif       (pb.port)
  );
  // ****************************************
  // Read windows of four entries
  // ****************************************
  logic [10:0] a_i1, a_i2, a_i3;
  logic [10:0] b_i1, b_i2, b_i3;
  assign a_i1 = pa.base + 11'h001;
  assign a_i2 = pa.base + 11'h002;
  assign a_i3 = pa.base + 11'h003;
  assign b_i1 = pb.base + 11'h001;
  assign b_i2 = pb.base + 11'h002;
  assign b_i3 = pb.base + 11'h003;
  assign pa.rslot = {ram[a_i3], ram[a_i2], ram[a_i1], ram[pa.base]}; // [RULE_07]
  assign pb.rslot = {ram[b_i3], ram[b_i2], ram[b_i1], ram[pb.base]}; // [RULE_07]
  // ****************************************
  // Entry update: load, then port A over port B
  // ****************************************
  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    localparam logic [10:0] IDX = 11'(i);
    logic [10:0] ka;
    logic [10:0] kb;
    logic [8:0]  ma;
    logic [8:0]  mb;
    logic [8:0]  da;
    logic [8:0]  db;
    logic [8:0]  next_ent;
    assign ka = IDX - pa.base;
    assign kb = IDX - pb.base;
    assign ma = (ka < SLOT_LIM) ? pa.wmask[9*ka[1:0] +: 9] : 9'h000;
    assign mb = (kb < SLOT_LIM) ? pb.wmask[9*kb[1:0] +: 9] : 9'h000;
    assign da = pa.wslot[9*ka[1:0] +: 9];
    assign db = pb.wslot[9*kb[1:0] +: 9];
    assign next_ent = (state == ST_LOAD && idx == IDX) ? shadow[i] : // [RULE_08]
                      ((((ram[i] & ~mb) | (db & mb)) & ~ma) | (da & ma)); // [RULE_11]
    always_ff @(posedge clk) begin
      ram[i] <= next_ent; // [RULE_01]
    end
  end
  always_ff @(posedge clk) begin
    if (state == ST_SAVE) shadow[idx] <= ram[idx]; // [RULE_09]
  end
  // ****************************************
  // Load and write-back sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_idx   = idx;
    unique case (state)
      ST_IDLE: begin
        next_idx = IDX_RST;
        if (reconfig_req) next_state = ST_LOAD; // [RULE_08]
        else if (writeback_req) next_state = ST_SAVE; // [RULE_10]
      end
      ST_LOAD, ST_SAVE: begin
        next_idx = idx + 11'h001;
        if (idx == IDX_LAST) next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
        next_idx   = IDX_RST;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_LOAD; // [RULE_08]
      idx       <= IDX_RST;
      cfg_error <= 1'b0;
    end else begin
      state     <= next_state;
      idx       <= next_idx;
      cfg_error <= next_cfg_error;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  a_tdp_shape: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
    (tdp && a_width == W36) |=> cfg_error) else $error("512x36 accepted in true dual-port");
  a_load_start: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_08]
    (state == ST_IDLE && reconfig_req) |=> (state == ST_LOAD && idx == IDX_RST)) else $error("reload not started");
  a_load_copy: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_08]
    (state == ST_LOAD) |=> (ram[$past(idx)] === $past(shadow[idx]))) else $error("load copy wrong");
  a_save_copy: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_09]
    (state == ST_SAVE) |=> (shadow[$past(idx)] === $past(ram[idx]))) else $error("write-back copy wrong");
  a_save_cause: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_10]
    (state == ST_IDLE) ##1 (state == ST_SAVE) |-> $past(writeback_req)) else $error("write-back without request");
  a_seq_end: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_08]
    (busy && idx == IDX_LAST) |=> (!busy && idx == IDX_RST)) else $error("copy did not end");
  a_sp_b_quiet: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
    !tdp |-> (pb.wmask == 36'h0)) else $error("port B wrote outside true dual-port");
  a_mode_illegal: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
    (mode == 2'h3) |=> cfg_error) else $error("illegal mode not flagged");
  a_pdp_a_quiet: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
    (pdp && $past(pdp) && $past(pdp, 2)) |-> !a_rvalid) else $error("port A read in pseudo dual-port");
  a_sp_b_noread: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
    (sp && $past(sp) && $past(sp, 2)) |-> !b_rvalid) else $error("port B read in single-port");
  a_idle_stay: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_10]
    (state == ST_IDLE && !reconfig_req && !writeback_req) |=> (state == ST_IDLE)) else $error("copy without request");
  a_busy_nowrite: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_08]
    busy |-> (pa.wmask == 36'h0 && pb.wmask == 36'h0)) else $error("write served while busy");
endmodule : ebram_top
`default_nettype wire

/* hw/ebram_pkg.sv */
// Constants and types shared by the embedded block RAM files
package ebram_pkg;
  // ****************************************
  // Storage geometry
  // ****************************************
  localparam int unsigned ENTRIES    = 2048;
  localparam int unsigned ENTRY_W    = 9;
  localparam int unsigned SLOTS      = 4;
  localparam int unsigned STORE_BITS = ENTRIES * ENTRY_W;
  localparam int unsigned WORD_W     = 36;
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned IDX_W      = 11;
  localparam logic [10:0] IDX_RST    = 11'h000;
  localparam logic [10:0] IDX_LAST   = 11'h7FF;
  localparam logic [10:0] SLOT_LIM   = 11'h004;
  // ****************************************
  // Read latency in clock cycles
  // ****************************************
  localparam int unsigned RD_LAT      = 1;
  localparam int unsigned RD_LAT_OREG = 2;
  // ****************************************
  // Codes
  // ****************************************
  typedef enum logic [2:0] {
    W1  = 3'h0,
    W2  = 3'h1,
    W4  = 3'h2,
    W9  = 3'h3,
    W18 = 3'h4,
    W36 = 3'h5
  } ebram_width_t;
  typedef enum logic [1:0] {
    MODE_SP  = 2'h0,
    MODE_TDP = 2'h1,
    MODE_PDP = 2'h2
  } ebram_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_SAVE = 2'h2
  } ebram_state_t;
endpackage : ebram_pkg

/* hw/ebram_port_if.sv */
// Link between one access port and the storage array
`timescale 1ns/1ps
`default_nettype none
interface ebram_port_if;
  logic [10:0] base;
  logic [35:0] wslot;
  logic [35:0] wmask;
  logic [35:0] rslot;
  modport port  (output base, output wslot, output wmask, input rslot);
  modport array (input base, input wslot, input wmask, output rslot);
endinterface : ebram_port_if
`default_nettype wire

/* hw/ebram_port.sv */
// One access port: address mapping, parity, byte enables, read pipeline
`timescale 1ns/1ps
`default_nettype none
module ebram_port (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic [2:0]             width,
  input  wire logic                   oreg_en,
  input  wire logic                   parity_en,
  input  wire logic                   tdp,
  input  wire logic                   wr_allow,
  input  wire logic                   rd_allow,
  input  wire logic                   busy,
  input  wire logic                   en,
  input  wire logic                   we,
  input  wire logic [13:0]            addr,
  input  wire logic [35:0]            wdata,
  input  wire logic [3:0]             be,
  output logic      [35:0]            rdata,
  output logic                        rvalid,
  output logic                        bad,
  ebram_port_if.port                  pif
);
  import ebram_pkg::*;
  // ****************************************
  // Address mapping
  // ****************************************
  logic [13:0] bit_idx;
  logic [2:0]  bit_off;
  logic        narrow;
  logic        legal;
  logic        do_wr;
  logic        do_rd;
  logic [7:0]  nmask;
  logic [3:0]  slot_on;
  logic [35:0] wdat_p;
  logic [35:0] wide_mask;
  logic [7:0]  nwdat;
  logic [7:0]  nwmsk;
  logic [7:0]  nrd;
  logic [35:0] rd_word;
  logic [35:0] stage;
  logic        stage_v;
  assign narrow  = (width < W9);
  assign nmask   = (width == W1) ? 8'h01 : (width == W2) ? 8'h03 : 8'h0F;
  assign bit_idx = (width == W1) ? addr : (width == W2) ? {addr[12:0], 1'b0} : {addr[11:0], 2'h0}; // [RULE_07]
  assign bit_off = bit_idx[2:0];
  assign pif.base = narrow ? bit_idx[13:3] : (width == W9) ? addr[10:0] :
                    (width == W18) ? {addr[9:0], 1'b0} : {addr[8:0], 2'h0}; // [RULE_03] [RULE_07]
  assign legal   = (width <= W36) && !(tdp && (width == W36)); // [RULE_03]
  assign bad     = !legal;
  assign do_wr   = en && we && wr_allow && legal && !busy; // [RULE_12]
  assign do_rd   = en && !we && rd_allow && legal && !busy; // [RULE_12]
  assign slot_on = (width == W36) ? 4'hF : (width == W18) ? 4'h3 : 4'h1;
  // ****************************************
  // Write data, parity and byte masks
  // ****************************************
  for (genvar k = 0; k < 4; k++) begin : g_byte
    assign wdat_p[9*k+7:9*k] = wdata[9*k+7:9*k];
    assign wdat_p[9*k+8]     = parity_en ? ^wdata[9*k+7:9*k] : wdata[9*k+8]; // [RULE_04]
    assign wide_mask[9*k+8:9*k] = {9{slot_on[k] && (narrow || width == W9 || be[k])}}; // [RULE_05]
  end
  assign nwdat     = (wdata[7:0] & nmask) << bit_off;
  assign nwmsk     = nmask << bit_off;
  assign pif.wslot = narrow ? {28'h0, nwdat} : wdat_p;
  assign pif.wmask = !do_wr ? 36'h0 : narrow ? {28'h0, nwmsk} : wide_mask;
  // ****************************************
  // Read extraction and pipeline
  // ****************************************
  assign nrd     = (pif.rslot[7:0] >> bit_off) & nmask;
  assign rd_word = narrow ? {28'h0, nrd} : (pif.rslot & {{18{width == W36}}, {9{width != W9}}, 9'h1FF});
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage   <= 36'h0;
      stage_v <= 1'b0;
    end else begin
      stage_v <= do_rd;
      if (do_rd) stage <= rd_word;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata  <= 36'h0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= oreg_en ? stage_v : do_rd; // [RULE_01] [RULE_12]
      if (oreg_en && stage_v) rdata <= stage;
      else if (!oreg_en && do_rd) rdata <= rd_word;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  a_rd_direct: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_12]
    (do_rd && !oreg_en) |=> (rvalid && rdata == $past(rd_word))) else $error("read data late");
  a_rd_oreg: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_12]
    (do_rd && oreg_en) ##1 oreg_en |=> rvalid) else $error("registered read not two cycles");
  a_wr_quiet: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_12]
    !(en && we) |-> (pif.wmask == 36'h0)) else $error("write without request");
  a_be_gate: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
    (do_wr && width == W36 && be == 4'h1) |-> (pif.wmask == 36'h0_0000_01FF)) else $error("byte enable ignored");
  a_parity_gen: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
    (do_wr && parity_en && width == W18) |-> (pif.wslot[17] == ^wdata[16:9])) else $error("parity wrong");
  a_busy_block: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_08]
    busy [*3] |-> !rvalid) else $error("read served while busy");
endmodule : ebram_port
`default_nettype wire

/* verif/ebram_user_model.sv */
// Fabric-side user logic that issues shadow copy requests
`timescale 1ns/1ps
`default_nettype none
module ebram_user_model (
  input  wire logic save_cmd,
  input  wire logic load_cmd,
  input  wire logic busy,
  output wire logic writeback_req,
  output wire logic reconfig_req
);
  // ****************************************
  // Request lines
  // ****************************************
  // Write-back only on an explicit command, never while a copy runs
  assign writeback_req = save_cmd & ~busy;
  assign reconfig_req  = load_cmd & ~busy;
endmodule : ebram_user_model
`default_nettype wire

/* verif/ebram_tb_top.sv */
// Self-checking bench for the embedded block RAM
`timescale 1ns/1ps
`default_nettype none
module ebram_tb_top;
  import ebram_pkg::*;
  logic        clk, rst_b, parity_en, save_cmd, load_cmd, busy, cfg_error, wb_req, rc_req;
  logic [1:0]  mode;
  logic [2:0]  wid[2];
  logic        oreg[2], en[2], we[2], rvalid[2];
  logic [13:0] addr[2];
  logic [35:0] wdata[2], rdata[2], old;
  logic [3:0]  be[2];
  logic [8:0]  cfg_tab[6];
  logic [7:0]  pat;
  int          miscompares, checked, n;

  ebram_user_model user_u (.save_cmd(save_cmd), .load_cmd(load_cmd), .busy(busy),
                           .writeback_req(wb_req), .reconfig_req(rc_req));
  ebram_top dut_u (
    .clk(clk), .rst_b(rst_b), .mode(mode), .parity_en(parity_en), .reconfig_req(rc_req),
    .writeback_req(wb_req), .a_width(wid[0]), .a_oreg_en(oreg[0]), .a_en(en[0]), .a_we(we[0]),
    .a_addr(addr[0]), .a_wdata(wdata[0]), .a_be(be[0]), .a_rdata(rdata[0]), .a_rvalid(rvalid[0]),
    .b_width(wid[1]), .b_oreg_en(oreg[1]), .b_en(en[1]), .b_we(we[1]), .b_addr(addr[1]),
    .b_wdata(wdata[1]), .b_be(be[1]), .b_rdata(rdata[1]), .b_rvalid(rvalid[1]), .busy(busy),
    .cfg_error(cfg_error));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic chk1(input string what, input logic seen, input logic exp);
    check(what, {35'h0, seen}, {35'h0, exp});
  endtask : chk1

  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] d, input logic [3:0] bm);
    logic [35:0] m;
    for (int k = 0; k < 4; k++) begin
      m[9*k +: 9] = {9{bm[k]}};
    end
    return (d & m) | (o & ~m);
  endfunction : merge

  task automatic wr(input int p, input logic [2:0] w, input logic [13:0] ad, input logic [35:0] d,
                    input logic [3:0] bm);
    @(negedge clk);
    wid[p] = w;
    addr[p] = ad;
    wdata[p] = d;
    be[p] = bm;
    we[p] = 1'b1;
    en[p] = 1'b1;
    @(negedge clk);
    en[p] = 1'b0;
  endtask : wr

  task automatic rd(input int p, input logic [2:0] w, input logic [13:0] ad, input logic [35:0] exp,
                    input logic ok, input string what);
    int lat;
    lat = oreg[p] ? RD_LAT_OREG : RD_LAT;
    @(negedge clk);
    wid[p] = w;
    addr[p] = ad;
    we[p] = 1'b0;
    en[p] = 1'b1;
    @(negedge clk);
    en[p] = 1'b0;
    repeat (lat - 1) begin
      chk1({what, " early"}, rvalid[p], 1'b0);
      @(negedge clk);
    end
    chk1({what, " valid"}, rvalid[p], ok);
    if (ok) begin
      check(what, rdata[p], exp);
    end
  endtask : rd

  task automatic busy_len(input string what);
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check(what, 36'(n), 36'(ENTRIES));
  endtask : busy_len

  task automatic shadow(input logic ld, input string what);
    @(negedge clk);
    save_cmd = ~ld;
    load_cmd = ld;
    @(negedge clk);
    save_cmd = 1'b0;
    load_cmd = 1'b0;
    busy_len(what);
  endtask : shadow

  // ****************************************
  // Clock, watchdog, tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    miscompares++;
    summarize();
  end

  initial begin
    miscompares = 0;
    checked = 0;
    rst_b = 1'b0;
    mode = MODE_SP;
    parity_en = 1'b0;
    save_cmd = 1'b0;
    load_cmd = 1'b0;
    pat = 8'hA5;
    cfg_tab = '{9'h0D7, 9'h0BB, 9'h1B7, 9'h067, 9'h15A, 9'h05E};
    for (int i = 0; i < 2; i++) begin
      wid[i] = W9;
      oreg[i] = 1'b0;
      en[i] = 1'b0;
      we[i] = 1'b0;
      addr[i] = 14'h0000;
      wdata[i] = 36'h0;
      be[i] = 4'hF;
    end
    repeat (5) @(negedge clk);
    chk1("busy in reset", busy, 1'b1);
    chk1("rvalid in reset", rvalid[0], 1'b0);
    rst_b = 1'b1;
    busy_len("power-up load");
    $display("test reset done");
    wr(0, W36, 14'h0005, 36'h123456789, 4'hF);
    rd(0, W36, 14'h0005, 36'h123456789, 1'b1, "x36 word");
    oreg[0] = 1'b1;
    rd(0, W36, 14'h0005, 36'h123456789, 1'b1, "x36 oreg word");
    oreg[0] = 1'b0;
    wr(0, W36, 14'h0005, 36'hFEDCBA987, 4'h5);
    old = merge(36'h123456789, 36'hFEDCBA987, 4'h5);
    rd(0, W36, 14'h0005, old, 1'b1, "x36 byte enables");
    wr(0, W36, 14'h0005, 36'h0000000AA, 4'h1);
    old = merge(old, 36'h0000000AA, 4'h1);
    rd(0, W36, 14'h0005, old, 1'b1, "x36 one byte");
    wr(0, W18, 14'h0020, 36'h3FFFF, 4'hF);
    wr(0, W18, 14'h0020, 36'h0, 4'h1);
    rd(0, W18, 14'h0020, 36'h3FE00, 1'b1, "x18 byte enables");
    parity_en = 1'b1;
    wr(0, W9, 14'h0010, 36'h007, 4'hF);
    rd(0, W9, 14'h0010, 36'h107, 1'b1, "parity odd byte");
    wr(0, W9, 14'h0010, 36'h1FF, 4'hF);
    rd(0, W9, 14'h0010, 36'h0FF, 1'b1, "parity even byte");
    wr(0, W18, 14'h0021, 36'h00207, 4'hF);
    rd(0, W18, 14'h0021, 36'h20307, 1'b1, "parity x18");
    parity_en = 1'b0;
    wr(0, W9, 14'h0010, 36'h103, 4'hF);
    rd(0, W9, 14'h0010, 36'h103, 1'b1, "user bit 8");
    $display("test single port done");
    // Ports never write one address in the same cycle
    mode = MODE_TDP;
    wr(0, W9, 14'h0000, 36'h100, 4'hF);
    wr(0, W9, 14'h0001, 36'h03C, 4'hF);
    for (int i = 0; i < 8; i++) begin
      wr(0, W1, 14'(i), {35'h0, pat[i]}, 4'hF);
    end
    rd(1, W9, 14'h0000, 36'h1A5, 1'b1, "B x9 entry 0");
    rd(1, W18, 14'h0000, 36'h079A5, 1'b1, "B x18 word 0");
    rd(1, W4, 14'h0001, 36'hA, 1'b1, "B x4 word 1");
    rd(1, W2, 14'h0001, 36'h1, 1'b1, "B x2 word 1");
    rd(1, W1, 14'h0007, 36'h1, 1'b1, "B x1 word 7");
    wr(1, W9, 14'h0002, 36'h0AB, 4'hF);
    rd(0, W9, 14'h0002, 36'h0AB, 1'b1, "A reads B write");
    $display("test dual port done");
    mode = MODE_PDP;
    wr(0, W36, 14'h0006, 36'hABCDE0123, 4'hF);
    rd(0, W36, 14'h0006, 36'h0, 1'b0, "A read in PDP");
    wr(1, W36, 14'h0006, 36'h0, 4'hF);
    rd(1, W36, 14'h0006, 36'hABCDE0123, 1'b1, "B x36 in PDP");
    $display("test pseudo dual port done");
    mode = MODE_SP;
    rd(1, W9, 14'h0002, 36'h0, 1'b0, "B read in SP");
    shadow(1'b0, "write-back length");
    wr(0, W36, 14'h0006, 36'h0, 4'hF);
    shadow(1'b1, "reload length");
    rd(0, W36, 14'h0006, 36'hABCDE0123, 1'b1, "reloaded word");
    $display("test shadow done");
    foreach (cfg_tab[i]) begin
      @(negedge clk);
      {mode, wid[0], wid[1]} = cfg_tab[i][8:1];
      @(negedge clk);
      chk1("cfg_error", cfg_error, cfg_tab[i][0]);
    end
    $display("test config done");
    summarize();
  end
endmodule : ebram_tb_top
`default_nettype wire
